/* rtl/apdu_pkg.sv */
// Shared constants and carrier types for the card-side message transport.
// Assumes a link layer that already frames blocks and checks their integrity.
package apdu_pkg;

  // ----------------------------------------------------------------
  // Buffer geometry and header layout
  // ----------------------------------------------------------------
  localparam int unsigned BUF_DEPTH = 512;   // Command bytes held, header included.
  localparam int unsigned BUF_AW    = 9;
  localparam int unsigned IFS_DEF   = 32;    // Default information field size.
  localparam logic [8:0]  HDR_LEN   = 9'h004;  // Class, instruction and two parameters.
  localparam logic [8:0]  DATA_OFS  = 9'h005;  // First command data byte in the buffer.
  localparam logic [1:0]  POS_CLA   = 2'h0;
  localparam logic [1:0]  POS_INS   = 2'h1;
  localparam logic [1:0]  POS_P1    = 2'h2;
  localparam logic [1:0]  POS_P2    = 2'h3;
  localparam logic [8:0]  POS_LEN   = 9'h004;  // First length byte.

  // ----------------------------------------------------------------
  // Instruction and status codes
  // ----------------------------------------------------------------
  localparam logic [7:0]  INS_ENVELOPE = 8'hC2;
  localparam logic [15:0] SW_OK        = 16'h9000;
  localparam logic [7:0]  SW1_PENDING  = 8'h91;
  localparam logic [15:0] SW_TK_BUSY   = 16'h9300;
  localparam logic [15:0] SW_BAD_LEN   = 16'h6700;  // Answer to a malformed message.
  localparam logic [7:0]  SW1_MORE     = 8'h61;
  localparam logic [7:0]  SW1_WARN_A   = 8'h62;
  localparam logic [7:0]  SW1_WARN_B   = 8'h63;
  localparam logic [3:0]  SW1_APP_HI   = 4'h9;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CASE_1 = 2'b00,   // No command data, no response data.
    CASE_2 = 2'b01,   // Response data only.
    CASE_3 = 2'b10,   // Command data only.
    CASE_4 = 2'b11    // Both.
  } case_e;

  typedef struct packed {
    logic [7:0] cla;
    logic [7:0] ins;
    logic [7:0] p1;
    logic [7:0] p2;
    case_e      kind;
    logic [7:0] lc;   // Command data length, zero for cases 1 and 2.
    logic [8:0] le;   // Expected length, 256 when the length byte is zero.
  } cmd_s;

  typedef struct packed {
    logic [7:0] data;
    logic       last;   // Last byte of the current block.
    logic       chain;  // The block carrying this byte is followed by another.
  } tx_s;

endpackage

/* rtl/cmd_buf_mem.sv */
// Simple one-write one-read byte memory holding a reassembled command.
// Assumes one clock; read data come out of a register one cycle later.
`timescale 1ns/10ps
module cmd_buf_mem #(
  parameter int unsigned DW    = 8,
  parameter int unsigned DEPTH = 512,
  parameter int unsigned AW    = 9
) (
  input  wire logic          mclk_i,   // Clock.
  input  wire logic          we_i,     // Write strobe.
  input  wire logic [AW-1:0] waddr_i,  // Write address.
  input  wire logic [DW-1:0] wdata_i,  // Write data.
  input  wire logic [AW-1:0] raddr_i,  // Read address.
  output logic      [DW-1:0] rdata_o   // Registered read data.
);

  logic [DW-1:0] mem_q [DEPTH];
  logic [DW-1:0] rdata_q;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Write and read both happen on the rising edge.
  always_ff @(posedge mclk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
    rdata_q <= mem_q[raddr_i];
  end

  assign rdata_o = rdata_q;

endmodule

/* rtl/apdu_block_transport.sv */
// Card-side message transport over a block-oriented link: command reassembly,
// case decoding, status screening and chained response emission.
// Assumes the link layer delivers information field bytes with block marks
// and accepts response bytes with their block marks.
//
// Notes on behaviour
// [RULE1] The terminal puts each command message unchanged into an information field.
// [RULE2] With status 61XX, 62XX, 63XX, 9XXX or 9000 the card returns available data.
// [RULE3] With any other status the card returns no data at all.
// [RULE4] The terminal hands the received information fields unchanged upward.
// [RULE5] A response may span several chained blocks that concatenate into one message.
// [RULE6] A command may span several chained blocks that concatenate into one message.
// [RULE7] Four cases exist: no data, response data only, command data only, and both.
// [RULE8] In place of 9000 the card may answer 91XX when a proactive command waits.
// [RULE9] The terminal fetches a waiting command with instruction 12 and length XX.
// [RULE10] The terminal reports the outcome with instruction 14 and the result data.
// [RULE11] When the toolkit cannot take an envelope the card answers 9300.
// [RULE12] An envelope is a case 4 command with instruction C2 and expected length 00.
// [RULE13] Envelope data with 9000 go to the terminal's acknowledgement channel.
// [RULE14] Envelope data with 62XX or 63XX go to the terminal's error channel.
// [RULE15] Pending command signalling works the same over every transport.
// [RULE16] Chained fields join in arrival order and end only with an unchained block.
`timescale 1ns/10ps
module apdu_block_transport #(
  parameter int unsigned IFS = apdu_pkg::IFS_DEF  // Bytes per response block.
) (
  input  wire logic                mclk_i,         // Clock, 200 MHz.
  input  wire logic                rst_i,          // Asynchronous reset, active high.
  input  wire logic                rx_valid_i,     // Received field byte present.
  input  wire logic [7:0]          rx_byte_i,      // Received field byte.
  input  wire logic                rx_last_i,      // Byte ends its block.
  input  wire logic                rx_chain_i,     // Block is chained to a next one.
  output apdu_pkg::tx_s            tx_o,           // Response byte with block marks.
  output logic                     tx_valid_o,     // Response byte present.
  input  wire logic                tx_ready_i,     // Link takes the response byte.
  output apdu_pkg::cmd_s           cmd_o,          // Decoded command header.
  output logic                     cmd_valid_o,    // One-cycle pulse: command ready.
  input  wire logic [7:0]          cmd_rd_idx_i,   // Command data byte index.
  output logic [7:0]               cmd_rd_data_o,  // Command data byte, one cycle later.
  input  wire logic                rsp_start_i,    // Application answer is ready.
  input  wire logic [15:0]         rsp_sw_i,       // Application status word.
  input  wire logic [8:0]          rsp_len_i,      // Response data length.
  input  wire logic [7:0]          rsp_byte_i,     // Current response data byte.
  output logic                     rsp_rd_o,       // One-cycle pulse: byte consumed.
  input  wire logic                pro_pending_i,  // Proactive command waiting.
  input  wire logic [7:0]          pro_len_i,      // Its length.
  input  wire logic                tk_busy_i       // Toolkit cannot take an envelope.
);

  typedef enum logic [2:0] {
    S_RX   = 3'b000,
    S_DEC  = 3'b001,
    S_WAIT = 3'b010,
    S_RD   = 3'b011,
    S_TX   = 3'b100
  } state_e;

  localparam logic [8:0] IFS_W = 9'(IFS);
  localparam logic [8:0] MAX_N = 9'(apdu_pkg::BUF_DEPTH - 1);

  state_e         state_q, state_d;
  logic [8:0]     n_q, n_d;
  logic [31:0]    hdr_q, hdr_d;
  logic [7:0]     b4_q, b4_d;
  logic [7:0]     lastb_q, lastb_d;
  apdu_pkg::cmd_s cmd_q, cmd_d;
  logic           cmd_valid_q, cmd_valid_d;
  logic           rsp_rd_q, rsp_rd_d;
  logic [8:0]     dcnt_q, dcnt_d;
  logic [15:0]    sw_q, sw_d;
  logic [8:0]     rem_q, rem_d;
  logic [8:0]     blk_q, blk_d;
  apdu_pkg::tx_s  tx_q, tx_d;
  logic           tx_valid_q, tx_valid_d;
  logic           mem_we;
  logic [8:0]     mem_raddr;

  // ----------------------------------------------------------------
  // Status screening helpers
  // ----------------------------------------------------------------
  // True for the status words that may carry response data.
  function automatic logic data_allowed(input logic [15:0] sw);
    logic [7:0] s1;
    s1 = sw[15:8];
    data_allowed = (s1 == apdu_pkg::SW1_MORE) ||                   // RULE2
                   (s1 == apdu_pkg::SW1_WARN_A) ||
                   (s1 == apdu_pkg::SW1_WARN_B) ||
                   (s1[7:4] == apdu_pkg::SW1_APP_HI);
  endfunction

  // Replaces a plain success by the pending-command status when one waits.
  function automatic logic [15:0] final_sw(input logic [15:0] sw, input logic pend,
                                           input logic [7:0] plen);
    if (sw == apdu_pkg::SW_OK && pend) begin
      final_sw = {apdu_pkg::SW1_PENDING, plen};                    // RULE8
    end else begin
      final_sw = sw;
    end
  endfunction

  // ----------------------------------------------------------------
  // Command buffer
  // ----------------------------------------------------------------
  // Bytes are stored at their arrival position, so chained fields line up in order.
  // The count stops at the top slot; a message that long is malformed in any case.
  assign mem_we    = (state_q == S_RX) && rx_valid_i && (n_q != MAX_N);  // RULE16
  assign mem_raddr = apdu_pkg::DATA_OFS + {1'b0, cmd_rd_idx_i};

  cmd_buf_mem #(
    .DW    (8),
    .DEPTH (apdu_pkg::BUF_DEPTH),
    .AW    (apdu_pkg::BUF_AW)
  ) u_buf (
    .mclk_i  (mclk_i),
    .we_i    (mem_we),
    .waddr_i (n_q),
    .wdata_i (rx_byte_i),
    .raddr_i (mem_raddr),
    .rdata_o (cmd_rd_data_o)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Receives, decodes, hands over and answers one command at a time.
  always_comb begin
    state_d     = state_q;
    n_d         = n_q;
    hdr_d       = hdr_q;
    b4_d        = b4_q;
    lastb_d     = lastb_q;
    cmd_d       = cmd_q;
    cmd_valid_d = 1'b0;
    rsp_rd_d    = 1'b0;
    dcnt_d      = dcnt_q;
    sw_d        = sw_q;
    rem_d       = rem_q;
    blk_d       = blk_q;
    tx_d        = tx_q;
    tx_valid_d  = tx_valid_q;
    unique case (state_q)
      S_RX: begin
        if (rx_valid_i) begin
          if (n_q != MAX_N) begin
            n_d = n_q + 9'h001;                                    // RULE6
          end
          if (n_q < apdu_pkg::HDR_LEN) begin
            hdr_d[8*(3-n_q[1:0]) +: 8] = rx_byte_i;
          end
          if (n_q == apdu_pkg::POS_LEN) begin
            b4_d = rx_byte_i;
          end
          lastb_d = rx_byte_i;
          if (rx_last_i && !rx_chain_i) begin
            state_d = S_DEC;                                       // RULE16
          end
        end
      end
      S_DEC: begin
        cmd_d.cla = hdr_q[31:24];
        cmd_d.ins = hdr_q[23:16];
        cmd_d.p1  = hdr_q[15:8];
        cmd_d.p2  = hdr_q[7:0];
        cmd_d.lc  = 8'h00;
        cmd_d.le  = 9'h000;
        cmd_d.kind = apdu_pkg::CASE_1;
        state_d   = S_WAIT;
        cmd_valid_d = 1'b1;
        // Length decoding picks one of the four data cases.
        if (n_q == apdu_pkg::HDR_LEN) begin
          cmd_d.kind = apdu_pkg::CASE_1;                           // RULE7
        end else if (n_q == apdu_pkg::DATA_OFS) begin
          cmd_d.kind = apdu_pkg::CASE_2;
          cmd_d.le   = (b4_q == 8'h00) ? 9'h100 : {1'b0, b4_q};
        end else if (b4_q != 8'h00 && n_q == apdu_pkg::DATA_OFS + {1'b0, b4_q}) begin
          cmd_d.kind = apdu_pkg::CASE_3;
          cmd_d.lc   = b4_q;
        end else if (b4_q != 8'h00 &&
                     n_q == apdu_pkg::DATA_OFS + {1'b0, b4_q} + 9'h001) begin
          cmd_d.kind = apdu_pkg::CASE_4;
          cmd_d.lc   = b4_q;
          cmd_d.le   = (lastb_q == 8'h00) ? 9'h100 : {1'b0, lastb_q};
        end else begin
          // Malformed length: refuse without involving the application.
          cmd_valid_d = 1'b0;
          sw_d        = apdu_pkg::SW_BAD_LEN;                      // RULE3
          dcnt_d      = 9'h000;
          rem_d       = 9'h002;
          blk_d       = 9'h000;
          state_d     = S_RD;
        end
        // An envelope the toolkit cannot take is turned back at once.
        if (hdr_q[23:16] == apdu_pkg::INS_ENVELOPE && tk_busy_i) begin
          cmd_valid_d = 1'b0;
          sw_d        = apdu_pkg::SW_TK_BUSY;                      // RULE11
          dcnt_d      = 9'h000;
          rem_d       = 9'h002;
          blk_d       = 9'h000;
          state_d     = S_RD;
        end
      end
      S_WAIT: begin
        if (rsp_start_i) begin
          sw_d = final_sw(rsp_sw_i, pro_pending_i, pro_len_i);     // RULE15
          if (data_allowed(rsp_sw_i)) begin
            dcnt_d = rsp_len_i;                                    // RULE2
          end else begin
            dcnt_d = 9'h000;                                       // RULE3
          end
          rem_d   = (data_allowed(rsp_sw_i) ? rsp_len_i : 9'h000) + 9'h002;
          blk_d   = 9'h000;
          state_d = S_RD;
        end
      end
      S_RD: begin
        // Data first, then the two status bytes, cut into blocks of IFS bytes.
        if (dcnt_q != 9'h000) begin
          tx_d.data = rsp_byte_i;
          rsp_rd_d  = 1'b1;
          dcnt_d    = dcnt_q - 9'h001;
        end else if (rem_q == 9'h002) begin
          tx_d.data = sw_q[15:8];
        end else begin
          tx_d.data = sw_q[7:0];
        end
        tx_d.last  = (blk_q == IFS_W - 9'h001) || (rem_q == 9'h001);  // RULE5
        tx_d.chain = rem_q > (IFS_W - blk_q);                         // RULE5
        blk_d      = tx_d.last ? 9'h000 : blk_q + 9'h001;
        rem_d      = rem_q - 9'h001;
        tx_valid_d = 1'b1;
        state_d    = S_TX;
      end
      S_TX: begin
        if (tx_ready_i) begin
          tx_valid_d = 1'b0;
          if (rem_q == 9'h000) begin
            n_d     = 9'h000;
            state_d = S_RX;
          end else begin
            state_d = S_RD;
          end
        end
      end
      default: begin
        state_d = S_RX;
      end
    endcase
  end

  // Registers the sequencer state.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q     <= S_RX;
      n_q         <= 9'h000;
      hdr_q       <= 32'h0000_0000;
      b4_q        <= 8'h00;
      lastb_q     <= 8'h00;
      cmd_q       <= '0;
      cmd_valid_q <= 1'b0;
      rsp_rd_q    <= 1'b0;
      dcnt_q      <= 9'h000;
      sw_q        <= 16'h0000;
      rem_q       <= 9'h000;
      blk_q       <= 9'h000;
      tx_q        <= '0;
      tx_valid_q  <= 1'b0;
    end else begin
      state_q     <= state_d;
      n_q         <= n_d;
      hdr_q       <= hdr_d;
      b4_q        <= b4_d;
      lastb_q     <= lastb_d;
      cmd_q       <= cmd_d;
      cmd_valid_q <= cmd_valid_d;
      rsp_rd_q    <= rsp_rd_d;
      dcnt_q      <= dcnt_d;
      sw_q        <= sw_d;
      rem_q       <= rem_d;
      blk_q       <= blk_d;
      tx_q        <= tx_d;
      tx_valid_q  <= tx_valid_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output is a flip-flop.
  assign tx_o        = tx_q;
  assign tx_valid_o  = tx_valid_q;
  assign cmd_o       = cmd_q;
  assign cmd_valid_o = cmd_valid_q;
  assign rsp_rd_o    = rsp_rd_q;

endmodule

/* sim/apdu_block_transport_sva.sv */
// Checker for the card-side message transport, watching its ports only.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/10ps
module apdu_block_transport_sva (
  input wire logic           mclk_i,         // Clock.
  input wire logic           rst_i,          // Reset.
  input wire logic           rx_valid_i,     // Field byte.
  input wire logic           rx_last_i,      // Block end.
  input wire logic           rx_chain_i,     // Chained.
  input wire apdu_pkg::tx_s  tx_o,           // Response byte.
  input wire logic           tx_valid_o,     // Byte present.
  input wire logic           tx_ready_i,     // Byte taken.
  input wire apdu_pkg::cmd_s cmd_o,          // Header.
  input wire logic           cmd_valid_o,    // Header pulse.
  input wire logic           rsp_start_i,    // Answer ready.
  input wire logic [15:0]    rsp_sw_i,       // Status.
  input wire logic [8:0]     rsp_len_i,      // Data length.
  input wire logic [7:0]     rsp_byte_i,     // Data byte.
  input wire logic           rsp_rd_o,       // Byte consumed.
  input wire logic           pro_pending_i,  // Pending.
  input wire logic           tk_busy_i       // Busy.
);
  logic wait_q;
  logic wait_d;
  logic ok_sw;
  logic take;

  // Tracks the window in which an application answer is taken.
  always_comb begin
    wait_d = wait_q;
    if (rsp_start_i) wait_d = 1'b0;
    else if (cmd_valid_o) wait_d = 1'b1;
  end
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) wait_q <= 1'b0;
    else wait_q <= wait_d;
  end
  assign ok_sw = (rsp_sw_i[15:8] inside {8'h61, 8'h62, 8'h63}) || (rsp_sw_i[15:12] == 4'h9);
  // An answer may already be taken in the cycle of the header pulse.
  assign take  = (wait_q || cmd_valid_o) && rsp_start_i;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  property p_cmd_end;
    cmd_valid_o |-> $past(rx_valid_i && rx_last_i && !rx_chain_i, 2);
  endproperty
  a_cmd_end: assert property (p_cmd_end) else $error("header without final block");
  property p_cmd_hold;
    cmd_valid_o |=> (!cmd_valid_o && $stable(cmd_o)) [*3];
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("header not held");
  property p_case_lc;
    cmd_valid_o && !cmd_o.kind[1] |-> cmd_o.lc == 8'h00;
  endproperty
  a_case_lc: assert property (p_case_lc) else $error("data length in case 1 or 2");
  property p_env_busy;
    cmd_valid_o && cmd_o.ins == apdu_pkg::INS_ENVELOPE |-> !$past(tk_busy_i);
  endproperty
  a_env_busy: assert property (p_env_busy) else $error("envelope passed while busy");
  property p_tx_hold;
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_o);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("response byte dropped");
  property p_tx_gap;
    tx_valid_o && tx_ready_i |=> !tx_valid_o;
  endproperty
  a_tx_gap: assert property (p_tx_gap) else $error("no gap after byte");
  property p_data_first;
    take && ok_sw && rsp_len_i != 9'h000 |->
      ##2 tx_valid_o && rsp_rd_o && tx_o.data == $past(rsp_byte_i, 2);
  endproperty
  a_data_first: assert property (p_data_first) else $error("data not sent first");
  property p_no_data;
    take && !ok_sw |->
      ##2 tx_valid_o && !rsp_rd_o && tx_o.data == $past(rsp_sw_i[15:8], 2);
  endproperty
  a_no_data: assert property (p_no_data) else $error("data sent with bad status");
  property p_pending;
    take && rsp_sw_i == apdu_pkg::SW_OK && pro_pending_i && rsp_len_i == 9'h000
      |-> ##2 tx_valid_o && tx_o.data == apdu_pkg::SW1_PENDING;
  endproperty
  a_pending: assert property (p_pending) else $error("pending command not flagged");

  c_case4: cover property (cmd_valid_o && cmd_o.kind == apdu_pkg::CASE_4);
  c_chain: cover property (tx_valid_o && tx_ready_i && tx_o.chain);
  c_bad_sw: cover property (take && !ok_sw);
endmodule

bind apdu_block_transport apdu_block_transport_sva u_apdu_block_transport_sva (
  .mclk_i(mclk_i), .rst_i(rst_i), .rx_valid_i(rx_valid_i), .rx_last_i(rx_last_i),
  .rx_chain_i(rx_chain_i), .tx_o(tx_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
  .cmd_o(cmd_o), .cmd_valid_o(cmd_valid_o), .rsp_start_i(rsp_start_i), .rsp_sw_i(rsp_sw_i),
  .rsp_len_i(rsp_len_i), .rsp_byte_i(rsp_byte_i), .rsp_rd_o(rsp_rd_o),
  .pro_pending_i(pro_pending_i), .tk_busy_i(tk_busy_i));

/* sim/apdu_link_model.sv */
// Terminal-side link model: sends commands as chained blocks, takes responses.
// Assumes the bench calls send and reads rq and done between messages.
`timescale 1ns/10ps
module apdu_link_model (
  input  wire logic          mclk_i,      // Clock.
  output logic               rx_valid_o,  // Field byte present.
  output logic [7:0]         rx_byte_o,   // Field byte.
  output logic               rx_last_o,   // Block end.
  output logic               rx_chain_o,  // More blocks follow.
  input  wire apdu_pkg::tx_s tx_i,        // Response byte.
  input  wire logic          tx_valid_i,  // Response byte present.
  output logic               tx_ready_o   // Response byte taken.
);
  logic          stall = 1'b0;
  logic          done = 1'b0;
  apdu_pkg::tx_s rq[$];

  // Ready is steady or random, so the card meets slow and prompt terminals.
  always @(negedge mclk_i) tx_ready_o <= stall ? 1'($urandom) : 1'b1;

  // Collects response bytes in arrival order; the message ends on an unchained end.
  always @(posedge mclk_i) begin
    if (tx_valid_i && tx_ready_o) begin
      rq.push_back(tx_i);
      done <= tx_i.last && !tx_i.chain;
    end
  end

  // Sends a command unchanged, cut into chained blocks of blk bytes.
  task automatic send(input logic [7:0] m[$], input int blk);
    for (int i = 0; i < m.size(); i++) begin
      @(negedge mclk_i);
      rx_valid_o = 1'b1;
      rx_byte_o  = m[i];
      rx_last_o  = (i % blk == blk - 1) || (i == m.size() - 1);
      rx_chain_o = rx_last_o && (i != m.size() - 1);
    end
    @(negedge mclk_i);
    rx_valid_o = 1'b0;
    rx_byte_o  = ~rx_byte_o;
    rx_last_o  = ~rx_last_o;
    rx_chain_o = ~rx_chain_o;
  endtask

  initial begin
    rx_valid_o = 1'b0;
    rx_byte_o  = 8'h00;
    rx_last_o  = 1'b0;
    rx_chain_o = 1'b0;
    tx_ready_o = 1'b0;
  end
endmodule

/* sim/apdu_block_transport_tb.sv */
// Self-checking bench for the card-side message transport.
// Assumes the link model as far side and the bench as application side.
`timescale 1ns/10ps
module apdu_block_transport_tb;
  localparam int unsigned IFS = 4;
  localparam logic [7:0] SW1_PICK [5] = '{8'h61, 8'h62, 8'h63, 8'h9A, 8'h6A};
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic rx_valid_i, rx_last_i, rx_chain_i, tx_valid_o, tx_ready_i, cmd_valid_o;
  logic rsp_start_i = 1'b0, rsp_rd_o, pro_pending_i = 1'b0, tk_busy_i = 1'b0;
  logic [7:0] rx_byte_i, cmd_rd_data_o, cmd_rd_idx_i = 8'h00, rsp_byte_i = 8'h00;
  logic [7:0] pro_len_i = 8'h00;
  logic [15:0] rsp_sw_i = 16'h0000;
  logic [8:0] rsp_len_i = 9'h000;
  logic [7:0] rdat[16];
  apdu_pkg::tx_s tx_o;
  apdu_pkg::cmd_s cmd_o;
  int mismatches = 0;
  int n_tests = 0;

  always #2.5 mclk_i = ~mclk_i;

  apdu_block_transport #(.IFS(IFS)) u_apdu_block_transport (.mclk_i(mclk_i), .rst_i(rst_i),
    .rx_valid_i(rx_valid_i), .rx_byte_i(rx_byte_i), .rx_last_i(rx_last_i),
    .rx_chain_i(rx_chain_i), .tx_o(tx_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
    .cmd_o(cmd_o), .cmd_valid_o(cmd_valid_o), .cmd_rd_idx_i(cmd_rd_idx_i),
    .cmd_rd_data_o(cmd_rd_data_o), .rsp_start_i(rsp_start_i), .rsp_sw_i(rsp_sw_i),
    .rsp_len_i(rsp_len_i), .rsp_byte_i(rsp_byte_i), .rsp_rd_o(rsp_rd_o),
    .pro_pending_i(pro_pending_i), .pro_len_i(pro_len_i), .tk_busy_i(tk_busy_i));
  apdu_link_model u_apdu_link_model (.mclk_i(mclk_i), .rx_valid_o(rx_valid_i),
    .rx_byte_o(rx_byte_i), .rx_last_o(rx_last_i), .rx_chain_o(rx_chain_i), .tx_i(tx_o),
    .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i));

  // Counts a comparison and reports a difference at once.
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (mismatches == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Works out the header decode from the raw command bytes.
  function automatic apdu_pkg::cmd_s exp_cmd(input logic [7:0] m[$]);
    apdu_pkg::cmd_s c;
    c = '0;
    c.cla = m[0];
    c.ins = m[1];
    c.p1 = m[2];
    c.p2 = m[3];
    if (m.size() == 5) begin
      c.kind = apdu_pkg::CASE_2;
      c.le = {m[4] == 8'h00, m[4]};
    end else if (m.size() > 5) begin
      c.lc = m[4];
      c.kind = (m.size() == 5 + m[4]) ? apdu_pkg::CASE_3 : apdu_pkg::CASE_4;
      if (c.kind == apdu_pkg::CASE_4) c.le = {m[m.size()-1] == 8'h00, m[m.size()-1]};
    end
    return c;
  endfunction

  // One command and its answer, checked byte by byte with block marks.
  task automatic xact(input logic [7:0] m[$], input int blk, input logic [15:0] sw,
                      input logic [8:0] len, input logic busy);
    logic [15:0] esw, rsw;
    int nd, n, k, r;
    logic seen;
    logic bad;
    for (k = 0; k < 16; k++) rdat[k] = 8'($urandom);
    tk_busy_i = busy;
    pro_len_i = 8'($urandom);
    esw = (sw == apdu_pkg::SW_OK && pro_pending_i) ? {apdu_pkg::SW1_PENDING, pro_len_i} : sw;
    nd = ((sw[15:8] inside {8'h61, 8'h62, 8'h63}) || sw[15:12] == 4'h9) ? int'(len) : 0;
    bad = m.size() > 5 &&
          (m[4] == 8'h00 || (m.size() != 5 + m[4] && m.size() != 6 + m[4]));
    if (bad) esw = apdu_pkg::SW_BAD_LEN;
    if (bad) nd = 0;
    if (busy) esw = apdu_pkg::SW_TK_BUSY;
    if (busy) nd = 0;
    u_apdu_link_model.done = 1'b0;
    u_apdu_link_model.rq.delete();
    u_apdu_link_model.send(m, blk);
    seen = 1'b0;
    for (k = 0; k < 20 && !seen; k++) begin
      @(negedge mclk_i);
      seen = cmd_valid_o;
    end
    check("cmd_valid", seen, !busy && !bad);
    if (seen) begin
      check("cmd", cmd_o, exp_cmd(m));
      for (k = 0; m.size() > 5 && k < m[4]; k++) begin
        cmd_rd_idx_i = 8'(k);
        @(negedge mclk_i);
        check("cmd_data", cmd_rd_data_o, m[5+k]);
      end
      rsp_sw_i = sw;
      rsp_len_i = len;
      rsp_byte_i = rdat[0];
      rsp_start_i = 1'b1;
      @(negedge mclk_i);
      rsp_start_i = 1'b0;
    end
    r = 0;
    for (k = 0; k < 400 && !u_apdu_link_model.done; k++) begin
      @(negedge mclk_i);
      if (rsp_rd_o) r++;
      if (rsp_rd_o) rsp_byte_i = rdat[r % 16];
    end
    n = nd + 2;
    check("rsp_count", u_apdu_link_model.rq.size(), n);
    for (k = 0; k < n && k < u_apdu_link_model.rq.size(); k++) begin
      check("rsp_byte", u_apdu_link_model.rq[k].data,
            k < nd ? rdat[k] : (k == nd ? esw[15:8] : esw[7:0]));
      check("rsp_marks", {u_apdu_link_model.rq[k].last, u_apdu_link_model.rq[k].chain},
            {(k % IFS == IFS - 1) || k == n - 1, k / IFS < (n - 1) / IFS});
    end
    // The terminal routes envelope data by the status that it received.
    if (m[1] == apdu_pkg::INS_ENVELOPE && u_apdu_link_model.rq.size() == n) begin
      rsw = {u_apdu_link_model.rq[n-2].data, u_apdu_link_model.rq[n-1].data};
      check("env_ack", rsw == apdu_pkg::SW_OK, esw == apdu_pkg::SW_OK);
      check("env_err", rsw[15:8] inside {8'h62, 8'h63},
            esw[15:8] inside {8'h62, 8'h63});
    end
  endtask

  // Cycles the four cases: fetch, terminal response and envelope among them.
  initial begin
    logic [7:0] m[$];
    logic [7:0] lc, plen;
    logic [15:0] sw;
    logic [8:0] len;
    int t, k, blk;
    void'($urandom(32'hF664AEAD));
    repeat (4) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_i = 1'b0;
    for (t = 0; t < 24; t++) begin
      plen = pro_len_i;
      lc = 8'(1 + $urandom % 12);
      m = {8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom)};
      m[1] = (t % 4 == 1) ? 8'h12 : (t % 4 == 2) ? 8'h14 : (t % 4 == 3) ? 8'hC2 : m[1];
      if (t % 4 == 1) m.push_back(plen);
      if (t % 4 > 1) m.push_back(lc);
      for (k = 0; k < lc && t % 4 > 1; k++) m.push_back(8'($urandom));
      if (t % 4 == 3) m.push_back(8'h00);
      if (t == 4) m = {m, 8'h00, 8'($urandom)};
      sw = {SW1_PICK[$urandom % 5], 8'($urandom)};
      if (t % 3 == 0) sw = apdu_pkg::SW_OK;
      pro_pending_i = (t % 6 == 0);
      len = (t == 1) ? 9'(IFS - 2) : (t == 0) ? 9'h000 : 9'($urandom % 10);
      blk = (t == 2) ? 1 : 1 + $urandom % 5;
      u_apdu_link_model.stall = t[0];
      xact(m, blk, sw, len, t % 8 == 7);
    end
    give_verdict();
  end

  // Cuts a hang short.
  initial begin
    #(30000 * 5);
    mismatches++;
    give_verdict();
  end
endmodule
